/* File: prxe_pkg.sv */
// Purpose: Shared constants and carriers for the receive error report block
// Assumes: 16-bit management registers addressed by 5-bit register number
// Notes: Bit positions and error nibbles are fixed by the register layout
package prxe_pkg;

  // Register numbers
  localparam logic [4:0] ADDR_ERR_MASK = 5'h18;
  localparam logic [4:0] ADDR_SELF_STATUS = 5'h19;

  // Error mask register fields
  localparam int BIT_CODE_EN = 0;
  localparam int BIT_PACKET_EN = 1;
  localparam int BIT_LINK_EN = 2;
  localparam int BIT_PE_SEL = 3;
  localparam int BIT_CODE_SEL = 4;
  localparam int BIT_STRIP_PRE = 7;
  localparam logic [15:0] ERR_MASK_RST = 16'h8020;

  // Self status register fields
  localparam int BIT_LINK_OK = 15;
  localparam int BIT_LOW_POWER = 14;
  localparam int BIT_RECEIVING = 13;
  localparam int BIT_DESCR_LOCK = 12;
  localparam int BIT_CRS_TMO_DIS = 11;
  localparam int BIT_AN_ENABLED = 10;
  localparam int BIT_PAUSE = 9;
  localparam int BIT_FEFI_EN = 8;
  localparam int BIT_FULL_DUPLEX = 7;
  localparam int BIT_MODE_10BT = 6;
  localparam logic [1:0] SELF_RW_RST = 2'h0;

  // Error nibbles placed on the receive data lines
  localparam logic [3:0] CODE_PE_SET = 4'h4;
  localparam logic [3:0] CODE_PE_CLR = 4'h6;
  localparam logic [3:0] CODE_LINK = 4'h3;
  localparam logic [3:0] CODE_PACKET = 4'h2;
  localparam logic [3:0] CODE_CE_SET = 4'h5;
  localparam logic [3:0] CODE_CE_CLR = 4'h6;

  // Error events from the receive decoder, one-cycle pulses
  typedef struct packed {
    logic code_err;
    logic link_err;
    logic packet_err;
  } prxe_evt_t;

  // Live link and mode status from the rest of the PHY
  typedef struct packed {
    logic link_ok;
    logic low_power;
    logic descr_lock;
    logic an_enabled;
    logic pause_ok;
    logic full_duplex;
    logic mode_10bt;
  } prxe_stat_t;

endpackage : prxe_pkg

/* File: prxe_pe_detect.sv */
// Purpose: Flags a 100 Mb/s stream that shows a second idle before its end delimiter
// Assumes: Symbol strobes are one-cycle pulses on the block clock
// Notes: One flag per frame at most; later idles are ignored until the end
module prxe_pe_detect (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Decoded symbol strobes
  input wire logic speed_100,
  input wire logic in_stream,
  input wire logic idle_sym,
  input wire logic esd_sym,
  // Detection result
  output logic pe_pulse
);

  typedef enum logic [3:0] {
    PE_WAIT = 4'h1,
    PE_STREAM = 4'h2,
    PE_ONE_IDLE = 4'h4,
    PE_FLAGGED = 4'h8
  } prxe_pe_state_t;

  prxe_pe_state_t state_r;
  prxe_pe_state_t state_nxt;

  // Second idle before the delimiter ends the frame early
  assign pe_pulse = (state_r == PE_ONE_IDLE) && idle_sym && speed_100 && !esd_sym;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PE_WAIT: begin
        if (in_stream && speed_100 && !esd_sym) begin
          state_nxt = PE_STREAM;
        end
      end
      PE_STREAM: begin
        if (esd_sym || !speed_100) begin
          state_nxt = PE_WAIT;
        end else if (idle_sym) begin
          state_nxt = PE_ONE_IDLE;
        end
      end
      PE_ONE_IDLE: begin
        if (esd_sym || !speed_100) begin
          state_nxt = PE_WAIT;
        end else if (idle_sym) begin
          state_nxt = PE_FLAGGED;
        end
      end
      PE_FLAGGED: begin
        // Hold until the delimiter, a stream drop or loss of 100 Mb/s so one frame reports once
        if (esd_sym || !in_stream || !speed_100) begin
          state_nxt = PE_WAIT;
        end
      end
      default: begin
        state_nxt = PE_WAIT;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= PE_WAIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  pe_after_esd_a: assert property (@(posedge clock) disable iff (rst)
    esd_sym |-> !pe_pulse)
    else $error("premature end flagged with delimiter present");

  pe_needs_idle_a: assert property (@(posedge clock) disable iff (rst)
    pe_pulse |-> idle_sym && speed_100 && $past(state_r) != PE_WAIT)
    else $error("premature end flagged without second idle");

endmodule : prxe_pe_detect

/* File: prxe_error_report.sv */
// Purpose: Receive error reporting controls and link status bits of a 10/100 PHY
// Assumes: All inputs come from logic on the same clock; register port is the
//   management access path already decoded to register number and strobes
// Notes: Error nibbles replace received data for one cycle with the error line high
module prxe_error_report (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Management register port
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [15:0] reg_rdata,
  // Receive stream from the decoder
  input wire logic rx_dv_in,
  input wire logic [3:0] rxd_in,
  input wire logic speed_100,
  input wire logic idle_sym,
  input wire logic esd_sym,
  input wire prxe_pkg::prxe_evt_t err_evt,
  // Status and mode from the rest of the PHY
  input wire prxe_pkg::prxe_stat_t stat_in,
  input wire logic legacy_compat_mode,
  input wire logic tx_er,
  // MII receive outputs toward the MAC
  output logic rx_dv,
  output logic [3:0] rxd,
  output logic rx_er,
  // Transmit side control
  output logic tx_halt,
  // Control bits used by neighbouring logic
  output logic strip_preamble_en
);

  logic [15:0] err_mask_r;
  logic [1:0] self_rw_r;
  prxe_pkg::prxe_stat_t stat_r;
  logic [15:0] rdata_r;
  logic rx_dv_r;
  logic [3:0] rxd_r;
  logic rx_er_r;
  logic tx_halt_r;
  logic pe_pulse;
  logic code_en_eff;
  logic [3:0] err_code;
  logic err_hit;
  logic [15:0] self_status;
  logic [15:0] rdata_nxt;
  logic wr_mask;
  logic wr_self;

  prxe_pe_detect u_pe_detect (
    .clock(clock),
    .rst(rst),
    .speed_100(speed_100),
    .in_stream(rx_dv_in),
    .idle_sym(idle_sym),
    .esd_sym(esd_sym),
    .pe_pulse(pe_pulse)
  );

  assign wr_mask = reg_wr_en && (reg_addr == prxe_pkg::ADDR_ERR_MASK);
  assign wr_self = reg_wr_en && (reg_addr == prxe_pkg::ADDR_SELF_STATUS);

  // Legacy mode gates the stored bit as well, so a stale 1 never leaks
  assign code_en_eff = err_mask_r[prxe_pkg::BIT_CODE_EN] && !legacy_compat_mode;

  // Error mask register
  always_ff @(posedge clock) begin
    if (rst) begin
      err_mask_r <= prxe_pkg::ERR_MASK_RST;
    end else begin
      if (wr_mask) begin
        err_mask_r[15:8] <= reg_wdata[15:8];
        err_mask_r[6:1] <= reg_wdata[6:1];
      end
      if (legacy_compat_mode) begin
        err_mask_r[prxe_pkg::BIT_CODE_EN] <= 1'b0;
        err_mask_r[prxe_pkg::BIT_STRIP_PRE] <= 1'b0;
      end else if (wr_mask) begin
        err_mask_r[prxe_pkg::BIT_CODE_EN] <= reg_wdata[prxe_pkg::BIT_CODE_EN];
        err_mask_r[prxe_pkg::BIT_STRIP_PRE] <= reg_wdata[prxe_pkg::BIT_STRIP_PRE];
      end
    end
  end

  assign strip_preamble_en = err_mask_r[prxe_pkg::BIT_STRIP_PRE];

  // Writable bits of the self status register
  always_ff @(posedge clock) begin
    if (rst) begin
      self_rw_r <= prxe_pkg::SELF_RW_RST;
    end else if (wr_self) begin
      self_rw_r <= {reg_wdata[prxe_pkg::BIT_CRS_TMO_DIS], reg_wdata[prxe_pkg::BIT_FEFI_EN]};
    end
  end

  // Status snapshot; reads lag the live condition by one cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      stat_r <= '0;
    end else begin
      stat_r <= stat_in;
    end
  end

  always_comb begin
    self_status = 16'h0000;
    self_status[prxe_pkg::BIT_LINK_OK] = stat_r.link_ok;
    self_status[prxe_pkg::BIT_LOW_POWER] = stat_r.low_power;
    self_status[prxe_pkg::BIT_RECEIVING] = rx_dv_r;
    self_status[prxe_pkg::BIT_DESCR_LOCK] = stat_r.descr_lock;
    self_status[prxe_pkg::BIT_CRS_TMO_DIS] = self_rw_r[1];
    self_status[prxe_pkg::BIT_AN_ENABLED] = stat_r.an_enabled;
    self_status[prxe_pkg::BIT_PAUSE] = stat_r.pause_ok;
    self_status[prxe_pkg::BIT_FEFI_EN] = self_rw_r[0];
    self_status[prxe_pkg::BIT_FULL_DUPLEX] = stat_r.full_duplex;
    self_status[prxe_pkg::BIT_MODE_10BT] = stat_r.mode_10bt;
  end

  // Read data, unknown register numbers read zero
  always_comb begin
    rdata_nxt = 16'h0000;
    if (reg_addr == prxe_pkg::ADDR_ERR_MASK) begin
      rdata_nxt = err_mask_r;
      rdata_nxt[prxe_pkg::BIT_CODE_EN] = code_en_eff;
    end else if (reg_addr == prxe_pkg::ADDR_SELF_STATUS) begin
      rdata_nxt = self_status;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_r <= 16'h0000;
    end else if (reg_rd_en) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // Error selection: premature end, then code, link, packet
  always_comb begin
    err_hit = 1'b0;
    err_code = rxd_in;
    if (pe_pulse) begin
      err_hit = 1'b1;
      err_code = err_mask_r[prxe_pkg::BIT_PE_SEL] ? prxe_pkg::CODE_PE_SET : prxe_pkg::CODE_PE_CLR;
    end else if (err_evt.code_err) begin
      err_hit = 1'b1;
      if (code_en_eff) begin
        err_code = rxd_in;
      end else begin
        err_code = err_mask_r[prxe_pkg::BIT_CODE_SEL] ? prxe_pkg::CODE_CE_SET : prxe_pkg::CODE_CE_CLR;
      end
    end else if (err_evt.link_err && err_mask_r[prxe_pkg::BIT_LINK_EN]) begin
      err_hit = 1'b1;
      err_code = prxe_pkg::CODE_LINK;
    end else if (err_evt.packet_err && err_mask_r[prxe_pkg::BIT_PACKET_EN]) begin
      err_hit = 1'b1;
      err_code = prxe_pkg::CODE_PACKET;
    end
  end

  // Receive outputs toward the MAC
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_dv_r <= 1'b0;
      rxd_r <= 4'h0;
      rx_er_r <= 1'b0;
    end else begin
      rx_dv_r <= rx_dv_in;
      rxd_r <= err_code;
      rx_er_r <= err_hit;
    end
  end

  assign rx_dv = rx_dv_r;
  assign rxd = rxd_r;
  assign rx_er = rx_er_r;

  // HALT request only while code report enable is clear
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_halt_r <= 1'b0;
    end else begin
      tx_halt_r <= tx_er && !code_en_eff;
    end
  end

  assign tx_halt = tx_halt_r;

  default clocking cb @(posedge clock);
  endclocking

  default disable iff (rst);

  sequence s_pe_event;
    pe_pulse;
  endsequence

  sequence s_pe_report(logic [3:0] code);
    rx_er && rxd == code;
  endsequence

  pe_nibble_a: assert property (
    s_pe_event |=> s_pe_report($past(err_mask_r[prxe_pkg::BIT_PE_SEL]) ? 4'h4 : 4'h6))
    else $error("premature end nibble wrong");

  link_report_a: assert property (
    err_evt.link_err && !pe_pulse && !err_evt.code_err && err_mask_r[prxe_pkg::BIT_LINK_EN]
    |=> rx_er && rxd == 4'h3)
    else $error("link error not reported as 3h");

  link_quiet_a: assert property (
    err_evt.link_err && !err_evt.packet_err && !pe_pulse && !err_evt.code_err
    && !err_mask_r[prxe_pkg::BIT_LINK_EN] |=> !rx_er)
    else $error("masked link error reached the MAC");

  packet_report_a: assert property (
    err_evt.packet_err && !err_evt.link_err && !pe_pulse && !err_evt.code_err
    |=> rx_er == $past(err_mask_r[prxe_pkg::BIT_PACKET_EN])
    && (!rx_er || rxd == 4'h2))
    else $error("packet error report wrong");

  code_pass_a: assert property (
    err_evt.code_err && !pe_pulse && code_en_eff |=> rx_er && rxd == $past(rxd_in))
    else $error("enabled code error not passed");

  code_nibble_a: assert property (
    err_evt.code_err && !pe_pulse && !code_en_eff
    |=> rx_er && rxd == ($past(err_mask_r[prxe_pkg::BIT_CODE_SEL]) ? 4'h5 : 4'h6))
    else $error("code error nibble wrong");

  halt_send_a: assert property (
    tx_er && !code_en_eff |=> tx_halt ##1 (tx_halt == $past(tx_er && !code_en_eff)))
    else $error("HALT not sent on transmit error");

  legacy_block_a: assert property (
    legacy_compat_mode |=> !err_mask_r[prxe_pkg::BIT_CODE_EN] && !code_en_eff)
    else $error("code report enable survives legacy mode");

  link_flag_a: assert property (
    reg_rd_en && reg_addr == prxe_pkg::ADDR_SELF_STATUS |=> reg_rdata[15] == $past(stat_r.link_ok)
    ##1 stat_r.link_ok == $past(stat_in.link_ok))
    else $error("link valid flag wrong");

  link_type_a: assert property (
    reg_rd_en && reg_addr == prxe_pkg::ADDR_SELF_STATUS
    |=> {reg_rdata[9], reg_rdata[7], reg_rdata[6]}
    == $past({stat_r.pause_ok, stat_r.full_duplex, stat_r.mode_10bt}))
    else $error("link type bits wrong");

  low_power_a: assert property (
    reg_rd_en && reg_addr == prxe_pkg::ADDR_SELF_STATUS && stat_r.low_power |=> reg_rdata[14])
    else $error("low power flag missing");

  receiving_a: assert property (
    reg_rd_en && reg_addr == prxe_pkg::ADDR_SELF_STATUS |=> reg_rdata[13] == $past(rx_dv))
    else $error("receiving flag does not mirror valid pin");

  // Masked or absent events must leave the received nibble untouched
  err_idle_a: assert property (
    !pe_pulse && !err_evt.code_err && !(err_evt.link_err && err_mask_r[prxe_pkg::BIT_LINK_EN])
    && !(err_evt.packet_err && err_mask_r[prxe_pkg::BIT_PACKET_EN]) |=> !rx_er && rxd == $past(rxd_in))
    else $error("receive nibble altered without a reportable error");

  code_en_write_a: assert property (
    wr_mask && !legacy_compat_mode
    |=> err_mask_r[prxe_pkg::BIT_CODE_EN] == $past(reg_wdata[prxe_pkg::BIT_CODE_EN]))
    else $error("code report enable write lost");

  halt_quiet_a: assert property (
    !tx_er || code_en_eff |=> !tx_halt)
    else $error("HALT requested without a transmit error");

  low_power_clr_a: assert property (
    reg_rd_en && reg_addr == prxe_pkg::ADDR_SELF_STATUS && !stat_r.low_power |=> !reg_rdata[14])
    else $error("low power flag set while awake");

  receive_mirror_a: assert property (
    1'b1 |=> rx_dv == $past(rx_dv_in))
    else $error("receive valid does not follow the decoder");

  // Checked through reset itself, so the default disable is overridden
  reset_flags_a: assert property (disable iff (1'b0)
    rst |=> !stat_r.link_ok && !stat_r.low_power && !rx_dv && reg_rdata == 16'h0000)
    else $error("status flags not cleared by reset");

endmodule : prxe_error_report

/* File: prxe_mac_model.sv */
// Purpose: MAC side of the receive interface for the error report bench
// Assumes: Same clock as the block; transmit error raised on bench request
// Notes: Counts error cycles so the bench can cross-check its own total
module prxe_mac_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Receive side from the block
  input wire logic rx_dv,
  input wire logic [3:0] rxd,
  input wire logic rx_er,
  // Transmit error request and line
  input wire logic send_err,
  output logic tx_er,
  // Observations
  output int err_cnt_r,
  output logic [3:0] last_nib_r
);
  timeunit 1ns;
  timeprecision 1ps;

  // Launched from a flop, as a real MAC would, so the block sees it one edge late
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_er <= 1'b0;
    end else begin
      tx_er <= send_err;
    end
  end

  // Error cycles count whether or not the frame is valid
  always_ff @(posedge clock) begin
    if (rst) begin
      err_cnt_r <= 0;
      last_nib_r <= 4'h0;
    end else if (rx_er) begin
      err_cnt_r <= err_cnt_r + 1;
      last_nib_r <= rxd;
    end
  end
endmodule : prxe_mac_model

/* File: tb.sv */
// Purpose: Self-checking bench for the receive error report block
// Assumes: Inputs change 1 ns after each rising edge
// Notes: Random masks and events from a fixed seed, plus idle-count corners
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; $display("BAD %0t got %0h exp %0h", $time, g, e); end end

  logic clock, rst, reg_wr_en, reg_rd_en, rx_dv_in, speed_100, idle_sym, esd_sym;
  logic legacy_compat_mode, tx_er, rx_dv, rx_er, tx_halt, strip_preamble_en, send_err, leg;
  logic [4:0] reg_addr, x;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [3:0] rxd_in, rxd, mac_nib;
  logic [7:0] m;
  logic [1:0] rw;
  prxe_pkg::prxe_evt_t err_evt, e;
  prxe_pkg::prxe_stat_t stat_in;
  int mac_errs, failures, n_checks, seed, exp_errs;

  prxe_error_report u_prxe_error_report (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .rx_dv_in(rx_dv_in), .rxd_in(rxd_in), .speed_100(speed_100), .idle_sym(idle_sym),
    .esd_sym(esd_sym), .err_evt(err_evt), .stat_in(stat_in), .legacy_compat_mode(legacy_compat_mode),
    .tx_er(tx_er), .rx_dv(rx_dv), .rxd(rxd), .rx_er(rx_er), .tx_halt(tx_halt),
    .strip_preamble_en(strip_preamble_en));

  prxe_mac_model u_prxe_mac_model (.clock(clock), .rst(rst), .rx_dv(rx_dv), .rxd(rxd), .rx_er(rx_er),
    .send_err(send_err), .tx_er(tx_er), .err_cnt_r(mac_errs), .last_nib_r(mac_nib));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
    end
  endtask : tick

  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr_en = 1'b1;
    tick(1);
    reg_wr_en = 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] v);
    reg_addr = a;
    reg_rd_en = 1'b1;
    tick(1);
    reg_rd_en = 1'b0;
    `CHK(reg_rdata, v)
  endtask : rd_chk

  // Expected {error line, nibble}; code beats link beats packet
  function automatic logic [4:0] exp_evt(logic [7:0] mk, logic lg, prxe_pkg::prxe_evt_t ev, logic [3:0] raw);
    if (ev.code_err) return {1'b1, (mk[0] & ~lg) ? raw : (mk[4] ? 4'h5 : 4'h6)};
    if (ev.link_err & mk[2]) return {1'b1, 4'h3};
    if (ev.packet_err & mk[1]) return {1'b1, 4'h2};
    return {1'b0, raw};
  endfunction : exp_evt

  function automatic logic [15:0] stat_exp(prxe_pkg::prxe_stat_t s, logic [1:0] w, logic dv);
    return {s.link_ok, s.low_power, dv, s.descr_lock, w[1], s.an_enabled, s.pause_ok, w[0],
      s.full_duplex, s.mode_10bt, 6'h00};
  endfunction : stat_exp

  // Second event is either another idle or an end delimiter
  task automatic pe_run(input logic spd, input logic two, input logic sel);
    wr(5'h18, {12'h000, sel, 3'b000});
    speed_100 = spd;
    rx_dv_in = 1'b1;
    tick(1);
    idle_sym = 1'b1;
    tick(1);
    idle_sym = two;
    esd_sym = ~two;
    tick(1);
    `CHK({rx_er, rx_er ? rxd : 4'h0}, {spd & two, (spd & two) ? (sel ? 4'h4 : 4'h6) : 4'h0})
    idle_sym = ~two;
    esd_sym = 1'b0;
    tick(1);
    `CHK(rx_er, 1'b0)
    idle_sym = 1'b0;
    rx_dv_in = 1'b0;
    tick(3);
  endtask : pe_run

  task automatic close_out();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (5000) @(posedge clock);
    failures++;
    close_out();
  end

  initial begin
    seed = 78;
    {rst, reg_wr_en, reg_rd_en, rx_dv_in, speed_100, idle_sym, esd_sym} = 7'h01 << 6;
    {legacy_compat_mode, send_err, reg_addr, reg_wdata, rxd_in} = '0;
    err_evt = '0;
    stat_in = '0;
    failures = 0;
    n_checks = 0;
    exp_errs = 0;
    tick(20);
    rst = 1'b0;
    rd_chk(5'h18, 16'h8020);
    tick(1);
    rd_chk(5'h19, 16'h0000);
    tick(1);
    rd_chk(5'h1C, 16'h0000);
    `CHK({rx_er, tx_halt, strip_preamble_en}, 3'b000)
    for (int i = 0; i < 60; i++) begin
      m = 8'($random(seed));
      leg = 1'($random(seed));
      legacy_compat_mode = leg;
      wr(5'h18, {8'h00, m});
      if (leg) m = m & 8'h7E;
      rd_chk(5'h18, {8'h00, m});
      e = prxe_pkg::prxe_evt_t'(3'($random(seed)));
      rxd_in = 4'($random(seed));
      err_evt = e;
      x = exp_evt(m, leg, e, rxd_in);
      tick(1);
      err_evt = '0;
      `CHK({rx_er, rxd}, x)
      exp_errs += int'(x[4]);
      send_err = 1'b1;
      tick(2);
      `CHK(tx_halt, ~(m[0] & ~leg))
      if (x[4]) `CHK(mac_nib, x[3:0])
      send_err = 1'b0;
      tick(2);
    end
    `CHK(mac_errs, exp_errs)
    legacy_compat_mode = 1'b0;
    pe_run(1'b1, 1'b1, 1'b1);
    pe_run(1'b1, 1'b1, 1'b0);
    pe_run(1'b0, 1'b1, 1'b1);
    pe_run(1'b1, 1'b0, 1'b0);
    for (int j = 0; j < 8; j++) begin
      stat_in = prxe_pkg::prxe_stat_t'(7'($random(seed)));
      rw = 2'($random(seed));
      d = 16'hFFFF;
      d[11] = rw[1];
      d[8] = rw[0];
      rx_dv_in = 1'($random(seed));
      wr(5'h19, d);
      tick(3);
      `CHK(rx_dv, rx_dv_in)
      rd_chk(5'h19, stat_exp(stat_in, rw, rx_dv_in));
    end
    close_out();
  end
endmodule : tb
